// ---- verilog/gscr_pkg.sv ----
// Package for the gauge status and command register block.
// Assumes a 32-bit APB slave with word-aligned registers at index * 4.
package gscr_pkg;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [14:0] IDX_GAUGE_CTRL  = 15'h7FE2;
  localparam logic [14:0] IDX_PREV_ITER   = 15'h7FE3;
  localparam logic [14:0] IDX_STANDBY     = 15'h7FF0;
  localparam logic [14:0] IDX_PROTECT     = 15'h7FF1;
  localparam logic [14:0] IDX_RESTORE     = 15'h7FF2;
  localparam logic [14:0] IDX_RESTART     = 15'h7FF3;
  localparam logic [14:0] IDX_ACC_TOGGLE  = 15'h7FF4;
  localparam logic [14:0] IDX_ACC_CLEAR   = 15'h7FF5;
  localparam logic [14:0] IDX_ACC_STATUS  = 15'h7FF8;
  localparam logic [14:0] IDX_INT_STATUS  = 15'h7FF9;
  localparam logic [14:0] IDX_INT_MASK    = 15'h7FFA;

  // ---------------------------------------------------------------
  // Field positions of the gauge control word
  // ---------------------------------------------------------------
  localparam int POS_ENABLE  = 0;
  localparam int POS_RUNNING = 1;
  localparam int POS_DONE    = 2;
  localparam int POS_READING = 3;
  localparam int POS_FIRST   = 4;

  // ---------------------------------------------------------------
  // Interrupt status bit positions
  // ---------------------------------------------------------------
  localparam int INT_DONE    = 0;
  localparam int INT_REFUSED = 1;
  localparam int INT_FIRST   = 2;
  localparam int INT_W       = 3;

  // ---------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------
  localparam logic [31:0] CMD_GO          = 32'h0000_0001;
  localparam logic [31:0] RST_PREV_ITER   = 32'h0000_0000;
  localparam logic [INT_W-1:0] RST_INT    = 3'h0;

  function automatic logic is_go(input logic [31:0] d);
    return d == CMD_GO;
  endfunction

endpackage

// ---- verilog/gscr_regs.sv ----
// Gauge status flags, previous iteration count and self-clearing commands.
// Assumes APB master on pclk and controller-side event inputs on pclk too.
`timescale 1ns/1ps
`default_nettype none

module gscr_regs
  import gscr_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              execute_request,
  input  wire logic              iteration_results_read,
  input  wire logic              output_fetch_active,
  input  wire logic              gauge_input_written,
  input  wire logic              gauge_output_read,
  input  wire logic [31:0]       gauge_iteration_counter,
  output var  logic              execute_accepted,
  output var  logic              virtual_gauge_enable,
  output var  logic              standby_pulse,
  output var  logic              safe_mode_pulse,
  output var  logic              restore_defaults_pulse,
  output var  logic              system_restart_pulse,
  output var  logic              accum_running,
  output var  logic              accum_clear_pulse,
  output var  logic              irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             en;
    logic             running;
    logic             done;
    logic             reading;
    logic             first;
    logic [31:0]      prev_iter;
    logic             exec_ack;
    logic             standby;
    logic             protect;
    logic             restore;
    logic             restart;
    logic             acc_run;
    logic             acc_clear;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
    logic             irq;
  } gscr_state_s;

  gscr_state_s cur;
  gscr_state_s next_cur;

  logic [14:0] idx;
  logic        aligned;
  logic        access;
  logic        commit;
  logic        wr;

  assign idx     = paddr[16:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign access  = psel && penable;
  // Register effects happen only at the edge where pready is seen high
  assign commit  = access && cur.ready;
  assign wr      = commit && pwrite && !cur.err;

  function automatic logic mapped(input logic [14:0] i);
    return i == IDX_GAUGE_CTRL || i == IDX_PREV_ITER || i == IDX_STANDBY ||
           i == IDX_PROTECT || i == IDX_RESTORE || i == IDX_RESTART ||
           i == IDX_ACC_TOGGLE || i == IDX_ACC_CLEAR || i == IDX_ACC_STATUS ||
           i == IDX_INT_STATUS || i == IDX_INT_MASK;
  endfunction

  function automatic logic cmd_hit(input logic [14:0] reg_idx);
    return wr && idx == reg_idx && is_go(pwdata);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [INT_W-1:0] ev;
    logic             refused;
    logic             enabling;
    logic             finish;
    ev       = '0;
    refused  = 1'b0;
    enabling = 1'b0;
    finish   = 1'b0;
    next_cur = cur;

    // Bus answer: one wait state, then a one-cycle pready
    next_cur.ready = access && !cur.ready;
    // Error flop rises only together with ready, so pslverr can come straight from it
    next_cur.err   = 1'b0;
    if (access && !cur.ready) begin
      next_cur.err   = !(aligned && mapped(idx));
      next_cur.rdata = '0;
      if (!pwrite && aligned) begin
        unique case (idx)
          IDX_GAUGE_CTRL: begin
            next_cur.rdata[POS_ENABLE]  = cur.en;
            next_cur.rdata[POS_RUNNING] = cur.running;
            next_cur.rdata[POS_DONE]    = cur.done;
            next_cur.rdata[POS_READING] = cur.reading;
            next_cur.rdata[POS_FIRST]   = cur.first;
          end
          IDX_PREV_ITER:  next_cur.rdata = cur.prev_iter;
          IDX_ACC_STATUS: next_cur.rdata[0] = cur.acc_run;
          IDX_INT_STATUS: next_cur.rdata[INT_W-1:0] = cur.int_stat;
          IDX_INT_MASK:   next_cur.rdata[INT_W-1:0] = cur.int_mask;
          // Command registers read back zero
          default:        next_cur.rdata = '0;
        endcase
      end
    end

    // Self-clearing commands: a write of anything but one is dropped
    next_cur.standby   = cmd_hit(IDX_STANDBY);
    next_cur.protect   = cmd_hit(IDX_PROTECT);
    next_cur.restore   = cmd_hit(IDX_RESTORE);
    next_cur.restart   = cmd_hit(IDX_RESTART);
    next_cur.acc_clear = cmd_hit(IDX_ACC_CLEAR);
    if (cmd_hit(IDX_ACC_TOGGLE)) begin
      next_cur.acc_run = !cur.acc_run;
    end

    // Gauge enable
    if (wr && idx == IDX_GAUGE_CTRL) begin
      next_cur.en = is_go(pwdata);
      enabling    = is_go(pwdata) && !cur.en;
    end

    // Iteration handshake
    next_cur.exec_ack = 1'b0;
    if (cur.en) begin
      if (execute_request) begin
        if (cur.done || cur.running) begin
          refused = 1'b1;
        end else begin
          next_cur.running  = 1'b1;
          next_cur.exec_ack = 1'b1;
        end
      end
      if (cur.running && iteration_results_read) begin
        finish             = 1'b1;
        next_cur.running   = 1'b0;
        next_cur.prev_iter = gauge_iteration_counter;
      end
      // A finish in the same cycle as a host output read still leaves done set
      if (gauge_output_read) begin
        next_cur.done = 1'b0;
      end
      if (finish) begin
        next_cur.done = 1'b1;
      end
      next_cur.reading = output_fetch_active;
      if (gauge_input_written) begin
        next_cur.first = 1'b0;
      end
    end
    if (enabling) begin
      next_cur.first = 1'b1;
    end
    // Disabled gauge shows no handshake state
    if (!next_cur.en) begin
      next_cur.running = 1'b0;
      next_cur.done    = 1'b0;
      next_cur.reading = 1'b0;
      next_cur.first   = 1'b0;
    end

    // Interrupts: set wins over a write-one clear
    ev[INT_DONE]    = finish;
    ev[INT_REFUSED] = refused;
    ev[INT_FIRST]   = enabling;
    if (wr && idx == IDX_INT_STATUS) begin
      next_cur.int_stat = cur.int_stat & ~pwdata[INT_W-1:0];
    end
    next_cur.int_stat = next_cur.int_stat | ev;
    if (wr && idx == IDX_INT_MASK) begin
      next_cur.int_mask = pwdata[INT_W-1:0];
    end
    next_cur.irq = |(next_cur.int_stat & next_cur.int_mask);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur           <= '0;
      cur.prev_iter <= RST_PREV_ITER;
      cur.int_stat  <= RST_INT;
      cur.int_mask  <= RST_INT;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata                 = cur.rdata;
  assign pready                 = cur.ready;
  assign pslverr                = cur.err;
  assign execute_accepted       = cur.exec_ack;
  assign virtual_gauge_enable   = cur.en;
  assign standby_pulse          = cur.standby;
  assign safe_mode_pulse        = cur.protect;
  assign restore_defaults_pulse = cur.restore;
  assign system_restart_pulse   = cur.restart;
  assign accum_running          = cur.acc_run;
  assign accum_clear_pulse      = cur.acc_clear;
  assign irq                    = cur.irq;

endmodule // gscr_regs

`default_nettype wire

// ---- sim/gscr_regs_monitor.sv ----
// Checker for the gauge status and command register block.
// Assumes it is bound to gscr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module gscr_regs_monitor
  import gscr_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              virtual_gauge_enable,
  input wire logic              standby_pulse,
  input wire logic              safe_mode_pulse,
  input wire logic              restore_defaults_pulse,
  input wire logic              system_restart_pulse,
  input wire logic              accum_running,
  input wire logic              accum_clear_pulse,
  input wire logic              execute_accepted,
  input wire logic              irq
);
  // ---------------------------------------------------------------
  // Decode of completed accesses
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc;
  logic        go;
  logic [14:0] idx;
  assign acc = psel && penable && pready;
  assign idx = paddr[16:2];
  assign go  = acc && pwrite && pwdata == CMD_GO && paddr[1:0] == 2'h0;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_standby_once: assert property (go && idx == IDX_STANDBY |=> standby_pulse ##1 !standby_pulse)
    else $error("standby pulse wrong");
  a_safe_once: assert property (go && idx == IDX_PROTECT |=> safe_mode_pulse ##1 !safe_mode_pulse)
    else $error("safe mode pulse wrong");
  a_restore_once: assert property (go && idx == IDX_RESTORE |=> restore_defaults_pulse ##1 !restore_defaults_pulse)
    else $error("restore pulse wrong");
  a_restart_once: assert property (go && idx == IDX_RESTART |=> system_restart_pulse ##1 !system_restart_pulse)
    else $error("restart pulse wrong");
  a_clear_once: assert property (go && idx == IDX_ACC_CLEAR |=> accum_clear_pulse ##1 !accum_clear_pulse)
    else $error("accumulation clear pulse wrong");
  a_toggle_flip: assert property (go && idx == IDX_ACC_TOGGLE |=> accum_running != $past(accum_running))
    else $error("accumulation state not toggled");
  a_other_ignored: assert property (acc && pwrite && idx == IDX_STANDBY && pwdata != CMD_GO |=> !standby_pulse)
    else $error("non-go command acted on");
  a_cmd_read_zero: assert property (acc && !pwrite && idx inside {[IDX_STANDBY:IDX_ACC_CLEAR]} |-> prdata == 32'h0)
    else $error("command register reads nonzero");
  a_off_flags_zero: assert property (acc && !pwrite && idx == IDX_GAUGE_CTRL && !virtual_gauge_enable
    |-> prdata[4:1] == 4'h0)
    else $error("flags nonzero while gauge disabled");
  a_enable_write: assert property (go && idx == IDX_GAUGE_CTRL |=> virtual_gauge_enable)
    else $error("gauge not enabled by go write");
  c_standby: cover property (go && idx == IDX_STANDBY);
  c_accept: cover property (execute_accepted);
  c_irq: cover property (irq);
endmodule // gscr_regs_monitor

bind gscr_regs gscr_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .virtual_gauge_enable(virtual_gauge_enable), .standby_pulse(standby_pulse), .safe_mode_pulse(safe_mode_pulse),
  .restore_defaults_pulse(restore_defaults_pulse), .system_restart_pulse(system_restart_pulse),
  .accum_running(accum_running), .accum_clear_pulse(accum_clear_pulse), .execute_accepted(execute_accepted),
  .irq(irq));
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the gauge status and command register block.
// Assumes gscr_regs with its bound checker; the bench plays APB master and controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
  import gscr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fetch = 0, er;
  logic [16:0] paddr = 0;
  logic [31:0] pwdata = 0, cnt = 0, prdata, rd;
  logic [3:0]  ev = 0;
  logic        pready, pslverr, acc_ok, en, sb, sm, rs, rr, run, cl, irq;
  int          err_total = 0, n_checks = 0, cyc = 0;
  gscr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .execute_request(ev[0]), .iteration_results_read(ev[1]), .output_fetch_active(fetch),
    .gauge_input_written(ev[2]), .gauge_output_read(ev[3]), .gauge_iteration_counter(cnt),
    .execute_accepted(acc_ok), .virtual_gauge_enable(en), .standby_pulse(sb), .safe_mode_pulse(sm),
    .restore_defaults_pulse(rs), .system_restart_pulse(rr), .accum_running(run), .accum_clear_pulse(cl), .irq(irq));
  initial forever #50 pclk = ~pclk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [14:0] i, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d;
    @(posedge pclk); penable <= 1;
    @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  // One-cycle controller event; index picks the event line
  task kick(input int k);
    @(posedge pclk); ev <= 4'(1 << k);
    @(posedge pclk); ev <= 4'h0;
  endtask
  task rchk(input logic [14:0] i, input logic [31:0] e);
    apb(0, i, 32'h0); `CHK(rd, e)
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin err_total++; finish_test; end
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk); presetn <= 1;
    rchk(IDX_GAUGE_CTRL, 32'h0);
    rchk(IDX_PREV_ITER, 32'h0);
    for (int k = 0; k < 6; k++) rchk(IDX_STANDBY + 15'(k), 32'h0);
    apb(0, 15'h0100, 32'h0); `CHK(er, 1'b1)
    apb(1, IDX_GAUGE_CTRL, CMD_GO); rchk(IDX_GAUGE_CTRL, 32'h11);
    apb(1, IDX_INT_MASK, 32'h4); rchk(IDX_INT_STATUS, 32'h4); `CHK(irq, 1'b1)
    apb(1, IDX_INT_STATUS, 32'h4); rchk(IDX_INT_STATUS, 32'h0); `CHK(irq, 1'b0)
    kick(2); rchk(IDX_GAUGE_CTRL, 32'h01);
    fetch <= 1; rchk(IDX_GAUGE_CTRL, 32'h09);
    fetch <= 0; cnt <= 32'h0000_1234; kick(0); #1 `CHK(acc_ok, 1'b1)
    rchk(IDX_GAUGE_CTRL, 32'h03);
    kick(1); rchk(IDX_GAUGE_CTRL, 32'h05);
    apb(1, IDX_PREV_ITER, 32'hFFFF); rchk(IDX_PREV_ITER, 32'h1234);
    kick(0); #1 `CHK(acc_ok, 1'b0)
    rchk(IDX_INT_STATUS, 32'h3);
    kick(3); rchk(IDX_GAUGE_CTRL, 32'h01);
    for (int k = 0; k < 6; k++) begin
      logic [5:0] base;
      base = (k == 5) ? 6'h10 : 6'h00;
      apb(1, IDX_STANDBY + 15'(k), 32'h2); #1 `CHK({cl, run, rr, rs, sm, sb}, base)
      apb(1, IDX_STANDBY + 15'(k), CMD_GO); #1 `CHK({cl, run, rr, rs, sm, sb}, base | 6'(1 << k))
      @(posedge pclk); #1 `CHK({cl, rr, rs, sm, sb}, 5'h0)
    end
    rchk(IDX_ACC_STATUS, 32'h1);
    apb(1, IDX_ACC_TOGGLE, CMD_GO); #1 `CHK(run, 1'b0)
    rchk(IDX_ACC_STATUS, 32'h0);
    apb(1, IDX_GAUGE_CTRL, 32'h2); fetch <= 1; rchk(IDX_GAUGE_CTRL, 32'h0);
    finish_test;
  end
endmodule // tb
`default_nettype wire
